// ---- iep_cpu_model.sv ----
// Core-side model: instruction completion pulses, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module iep_cpu_model (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic slow,
    output var  logic cpu_insn_done
);
    logic [2:0] cnt_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= 3'h0;
            cpu_insn_done <= 1'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            // Slow mode mimics long instructions after a return
            cpu_insn_done <= slow ? (cnt_r == 3'h7) : cnt_r[0];
        end
    end
endmodule
`default_nettype wire

// ---- iep_defines.vh ----
// Register map, reset values and timing constants of the interrupt enable and priority block
`ifndef IEP_DEFINES_VH
`define IEP_DEFINES_VH

// Printed offsets are not all multiples of four: each is an index, byte address = 4 * index
`define IEP_IDX_PRIO_BASE      8'hB8
`define IEP_IDX_ENABLE_EXT     8'hE6
`define IEP_IDX_PRIO_EXT       8'hF6
`define IEP_IDX_ENABLE_BASE    8'hA8
`define IEP_IDX_SERVICE        8'hC0

`define IEP_RST_PRIO_BASE      8'h80
`define IEP_RST_ENABLE_EXT     8'h00
`define IEP_RST_PRIO_EXT       8'h00
`define IEP_RST_ENABLE_BASE    8'h00

`define IEP_BIT_GLOBAL_EN      7
`define IEP_BIT_PRIO_BASE_TOP  7

// Service register command bits
`define IEP_SVC_ACK            0
`define IEP_SVC_RETURN         1

`define IEP_NUM_SRC            15
`define IEP_VEC_W              4
`define IEP_NO_SRC             4'hF

// Detect-to-call timing in cycles
`define IEP_DETECT_CYCLES      1
`define IEP_CALL_CYCLES        4

`define IEP_RESP_OKAY          2'b00
`define IEP_RESP_SLVERR        2'b10

`endif

// ---- iep_irq_ctrl.v ----
// Interrupt enable masks, two-level priority and request arbitration with AXI4-Lite registers
// Summary of operation
// R1: Base priority top bit reads one, ignores writes
// R2: Base priority bit 6: SPI level
// R3: Base priority bit 5: timer 2 level
// R4: Base priority bit 4: UART level
// R5: Base priority bit 3: timer 1 level
// R6: Base priority bit 2: external interrupt 1 level
// R7: Base priority bit 1: timer 0 level
// R8: Base priority bit 0: external interrupt 0 level
// R9: Extended enable bit 7 masks port match
// R10: Extended enable bit 6 masks regulator dropout
// R11: Extended enable bit 5 masks LIN
// R12: Extended enable bit 4 masks comparator rise
// R13: Extended enable bit 3 masks comparator fall
// R14: Extended enable bit 2 masks counter array
// R15: Extended enable bit 1 gates ADC done
// R16: Extended enable bit 0 gates ADC window
// R17: Extended priority bit 7: port match level
// R18: Extended priority bit 6: regulator level
// R19: Extended priority bit 5: LIN level
// R20: Extended priority bits 4,3: comparator levels
// R21: Extended priority bit 2: counter array level
// R22: Extended priority bits 1,0: ADC levels
// R23: Global enable overrides every individual mask
// R24: Sample every cycle; detect then four-cycle call
// R25: Equal/higher handler blocks until return plus one
// R26: High preempts low; lower order number first
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "iep_defines.vh"

module iep_irq_ctrl #(
    parameter integer CALL_CYCLES = `IEP_CALL_CYCLES
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire [14:0] src_req,
    input  wire        cpu_insn_done,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         irq_call_r,
    output reg  [3:0]  irq_vector_r,
    output reg         irq_level_high_r,
    output reg  [1:0]  irq_active_r
);
    // Source index = fixed priority order number (0 highest):
    // 0 ext0, 1 tmr0, 2 ext1, 3 tmr1, 4 uart, 5 tmr2, 6 spi, 7 adc window,
    // 8 adc done, 9 counter array, 10 cmp fall, 11 cmp rise, 12 lin, 13 regulator, 14 port match

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_CALL = 4'b0010;
    localparam [3:0] ST_RUN  = 4'b0100;
    localparam [3:0] ST_POST = 4'b1000;

    reg  [7:0]  prio_base_r;
    reg  [7:0]  enable_ext_r;
    reg  [7:0]  prio_ext_r;
    reg  [7:0]  enable_base_r;

    reg  [31:0] awaddr_r;
    reg         aw_held_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         w_held_r;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [2:0]  call_cnt_r;
    reg  [14:0] req_s_r;
    reg  [1:0]  act_stack_r;
    reg  [3:0]  vec_pend_r;
    reg         lvl_pend_r;
    reg         svc_return;

    wire [14:0] src_en;
    wire [14:0] src_hi;
    wire [14:0] pend;
    wire [14:0] pend_hi;
    wire [14:0] pend_lo;
    wire [3:0]  pick_hi;
    wire [3:0]  pick_lo;
    wire        want_hi;
    wire        want_lo;

    function [7:0] iep_idx;
        input [31:0] addr;
        begin
            iep_idx = addr[9:2];
        end
    endfunction

    function [3:0] iep_first;
        input [14:0] v;
        integer k;
        begin
            iep_first = `IEP_NO_SRC;
            for (k = `IEP_NUM_SRC - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    iep_first = k[3:0];
                end
            end
        end
    endfunction

    function iep_mapped;
        input [7:0] idx;
        begin
            iep_mapped = (idx == `IEP_IDX_PRIO_BASE) || (idx == `IEP_IDX_ENABLE_EXT)
                      || (idx == `IEP_IDX_PRIO_EXT) || (idx == `IEP_IDX_ENABLE_BASE)
                      || (idx == `IEP_IDX_SERVICE);
        end
    endfunction

    // Base sources 0..6 take the base enable bits in order; extended 7..14 take ext bits
    assign src_en = {enable_ext_r[7], enable_ext_r[6], enable_ext_r[5], enable_ext_r[4], // R9 R10 R11 R12
                     enable_ext_r[3], enable_ext_r[2], enable_ext_r[1], enable_ext_r[0], // R13 R14 R15 R16
                     enable_base_r[6], enable_base_r[5], enable_base_r[4], enable_base_r[3],
                     enable_base_r[2], enable_base_r[1], enable_base_r[0]};
    assign src_hi = {prio_ext_r[7], prio_ext_r[6], prio_ext_r[5],                       // R17 R18 R19
                     prio_ext_r[4], prio_ext_r[3], prio_ext_r[2],                       // R20 R21
                     prio_ext_r[1], prio_ext_r[0],                                      // R22
                     prio_base_r[6], prio_base_r[5], prio_base_r[4], prio_base_r[3],    // R2 R3 R4 R5
                     prio_base_r[2], prio_base_r[1], prio_base_r[0]};                   // R6 R7 R8

    assign pend    = req_s_r & src_en & {15{enable_base_r[`IEP_BIT_GLOBAL_EN]}};      // R23
    assign pend_hi = pend & src_hi;
    assign pend_lo = pend & ~src_hi;
    assign pick_hi = iep_first(pend_hi);                                               // R26
    assign pick_lo = iep_first(pend_lo);                                               // R26
    // High may interrupt anything but a high handler; low only when nothing runs
    assign want_hi = (|pend_hi) && !act_stack_r[1];                                    // R25 R26
    assign want_lo = (|pend_lo) && (act_stack_r == 2'b00);                             // R25

    // Request lines come from logic on this clock and are sampled each cycle
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_s_r <= 15'h0000;
        end else begin
            req_s_r <= src_req;                                                        // R24
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (want_hi || want_lo) begin
                    state_nxt = ST_CALL;                                               // R24
                end
            end
            ST_CALL: begin
                if (call_cnt_r == 3'd1) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (svc_return) begin
                    state_nxt = ST_POST;
                end else if (want_hi) begin
                    state_nxt = ST_CALL;                                               // R26
                end
            end
            ST_POST: begin
                if (cpu_insn_done) begin
                    state_nxt = (act_stack_r == 2'b00) ? ST_IDLE : ST_RUN;             // R25
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r          <= ST_IDLE;
            call_cnt_r       <= 3'd0;
            act_stack_r      <= 2'b00;
            vec_pend_r       <= `IEP_NO_SRC;
            lvl_pend_r       <= 1'b0;
            irq_call_r       <= 1'b0;
            irq_vector_r     <= `IEP_NO_SRC;
            irq_level_high_r <= 1'b0;
            irq_active_r     <= 2'b00;
        end else begin
            state_r    <= state_nxt;
            irq_call_r <= 1'b0;
            if (state_nxt == ST_CALL && state_r != ST_CALL) begin
                // Latch the winner at detection so a late arrival cannot change the vector
                vec_pend_r <= want_hi ? pick_hi : pick_lo;
                lvl_pend_r <= want_hi;
                call_cnt_r <= CALL_CYCLES[2:0];                                        // R24
            end else if (state_r == ST_CALL) begin
                call_cnt_r <= call_cnt_r - 3'd1;
            end
            if (state_r == ST_CALL && call_cnt_r == 3'd1) begin
                irq_call_r       <= 1'b1;                                              // R24
                irq_vector_r     <= vec_pend_r;
                irq_level_high_r <= lvl_pend_r;
                if (lvl_pend_r) begin
                    act_stack_r[1] <= 1'b1;
                end else begin
                    act_stack_r[0] <= 1'b1;
                end
            end else if (state_r == ST_RUN && svc_return) begin
                // Return ends the highest running level
                if (act_stack_r[1]) begin
                    act_stack_r[1] <= 1'b0;
                end else begin
                    act_stack_r[0] <= 1'b0;
                end
            end
            irq_active_r <= act_stack_r;
        end
    end

    // AXI4-Lite write: address and data accepted in either order, response after both
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `IEP_RESP_OKAY;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 32'h00000000;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            prio_base_r   <= `IEP_RST_PRIO_BASE;
            enable_ext_r  <= `IEP_RST_ENABLE_EXT;
            prio_ext_r    <= `IEP_RST_PRIO_EXT;
            enable_base_r <= `IEP_RST_ENABLE_BASE;
            svc_return    <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            svc_return    <= 1'b0;
            if (s_axi_awvalid && !aw_held_r && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                aw_held_r     <= 1'b1;
            end
            if (s_axi_wvalid && !w_held_r && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                w_held_r     <= 1'b1;
            end
            if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= iep_mapped(iep_idx(awaddr_r)) ? `IEP_RESP_OKAY
                                                               : `IEP_RESP_SLVERR;
                if (wstrb_r[0]) begin
                    case (iep_idx(awaddr_r))
                        `IEP_IDX_PRIO_BASE: begin
                            prio_base_r <= {1'b1, wdata_r[6:0]};                       // R1
                        end
                        `IEP_IDX_ENABLE_EXT: begin
                            enable_ext_r <= wdata_r[7:0];
                        end
                        `IEP_IDX_PRIO_EXT: begin
                            prio_ext_r <= wdata_r[7:0];
                        end
                        `IEP_IDX_ENABLE_BASE: begin
                            enable_base_r <= wdata_r[7:0];
                        end
                        `IEP_IDX_SERVICE: begin
                            svc_return <= wdata_r[`IEP_SVC_RETURN];                   // R25
                        end
                        default: begin
                            svc_return <= 1'b0;
                        end
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read: data offered the cycle after the address handshake completes
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `IEP_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rresp   <= iep_mapped(iep_idx(s_axi_araddr)) ? `IEP_RESP_OKAY
                                                                    : `IEP_RESP_SLVERR;
                case (iep_idx(s_axi_araddr))
                    `IEP_IDX_PRIO_BASE: begin
                        s_axi_rdata <= {24'h000000, 1'b1, prio_base_r[6:0]};           // R1
                    end
                    `IEP_IDX_ENABLE_EXT: begin
                        s_axi_rdata <= {24'h000000, enable_ext_r};
                    end
                    `IEP_IDX_PRIO_EXT: begin
                        s_axi_rdata <= {24'h000000, prio_ext_r};
                    end
                    `IEP_IDX_ENABLE_BASE: begin
                        s_axi_rdata <= {24'h000000, enable_base_r};
                    end
                    `IEP_IDX_SERVICE: begin
                        s_axi_rdata <= {20'h00000, state_r, irq_vector_r, 2'b00, act_stack_r};
                    end
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                    end
                endcase
            end
            // Raising rvalid with arready would answer before the address is taken
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- iep_irq_ctrl_asserts.sv ----
// Port-level checker for the interrupt enable and priority block
`timescale 1ns/10ps
`default_nettype none
module iep_irq_asserts #(
    parameter integer CALL_CYCLES = 4
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq_call_r,
    input wire logic [3:0]  irq_vector_r,
    input wire logic        irq_level_high_r,
    input wire logic [1:0]  irq_active_r
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    chk_call_pulse: assert property (irq_call_r |=> !irq_call_r)
        else $error("call pulse longer than one cycle");
    chk_vector_hold: assert property (!irq_call_r |-> $stable({irq_vector_r, irq_level_high_r}))
        else $error("vector changed without a call");
    chk_active_set: assert property (irq_call_r |=> irq_active_r[irq_level_high_r])
        else $error("active flag not set after call");
    chk_high_blocks: assert property (irq_active_r[1] |-> !irq_call_r)
        else $error("call while high handler runs");
    chk_low_preempt: assert property (irq_call_r && irq_active_r[0] |-> irq_level_high_r)
        else $error("low call nested in low handler");
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid)
        else $error("write response late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rd_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
        |=> s_axi_arready ##1 s_axi_rvalid)
        else $error("read answer late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    cov_high_call: cover property (irq_call_r && irq_level_high_r);
    cov_preempt: cover property (irq_call_r && irq_active_r[0]);
    cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind iep_irq_ctrl iep_irq_asserts #(.CALL_CYCLES(CALL_CYCLES)) iep_irq_asserts_inst (
    .mclk(mclk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_call_r(irq_call_r),
    .irq_vector_r(irq_vector_r), .irq_level_high_r(irq_level_high_r), .irq_active_r(irq_active_r));
`default_nettype wire

// ---- tb_irq_enable_priority_regs.sv ----
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/10ps
`default_nettype none
`include "iep_defines.vh"
module tb_irq_enable_priority_regs;
    localparam logic [31:0] A_PB = {22'h0, `IEP_IDX_PRIO_BASE, 2'h0};
    localparam logic [31:0] A_EE = {22'h0, `IEP_IDX_ENABLE_EXT, 2'h0};
    localparam logic [31:0] A_PE = {22'h0, `IEP_IDX_PRIO_EXT, 2'h0};
    localparam logic [31:0] A_EB = {22'h0, `IEP_IDX_ENABLE_BASE, 2'h0};
    localparam logic [31:0] A_SV = {22'h0, `IEP_IDX_SERVICE, 2'h0};
    logic        mclk, rst, slow, cpu_insn_done;
    logic [14:0] src_req;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb, irq_vector_r;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_active_r, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        irq_call_r, irq_level_high_r;
    logic [7:0]  pat [2] = '{8'hA5, 8'h5A};
    int          mismatches = 0, check_count = 0, calls = 0, cycles = 0, lat;
    iep_irq_ctrl iep_irq_ctrl_inst (.mclk(mclk), .rst(rst), .src_req(src_req),
        .cpu_insn_done(cpu_insn_done), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq_call_r(irq_call_r), .irq_vector_r(irq_vector_r),
        .irq_level_high_r(irq_level_high_r), .irq_active_r(irq_active_r));
    iep_cpu_model iep_cpu_model_inst (.mclk(mclk), .rst(rst), .slow(slow),
        .cpu_insn_done(cpu_insn_done));
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (irq_call_r === 1'h1) calls <= calls + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] st);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= st;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [31:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        resp = s_axi_rresp;
        rdat = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
        axi_rd(a);
        chk($sformatf("reg %h", a), {24'h0, e}, rdat);
    endtask
    // Waits for a call, checks it, then withdraws the request so it is not taken again
    task automatic serve(input int v, input logic hi);
        lat = 0;
        do begin
            @(posedge mclk);
            #1;
            lat++;
        end while (irq_call_r !== 1'h1 && lat < 60);
        chk("call", 32'h1, {31'h0, irq_call_r});
        chk("vector", v, {28'h0, irq_vector_r});
        chk("level", {31'h0, hi}, {31'h0, irq_level_high_r});
        @(posedge mclk);
        src_req[v] <= 1'h0;
    endtask
    task automatic ret();
        axi_wr(A_SV, 8'h02, 4'hF);
    endtask
    task automatic t_regs();
        rdchk(A_PB, 8'h80);
        rdchk(A_EE, 8'h00);
        rdchk(A_PE, 8'h00);
        rdchk(A_EB, 8'h00);
        axi_wr(A_PB, 8'h7F, 4'hF);
        chk("bresp", {30'h0, `IEP_RESP_OKAY}, {30'h0, resp});
        rdchk(A_PB, 8'hFF);
        axi_wr(A_PB, 8'h00, 4'hF);
        rdchk(A_PB, 8'h80);
        foreach (pat[i]) begin
            axi_wr(A_EE, pat[i], 4'hF);
            axi_wr(A_PE, ~pat[i], 4'hF);
            rdchk(A_EE, pat[i]);
            rdchk(A_PE, ~pat[i]);
        end
        axi_wr(A_PE, 8'hFF, 4'h0);
        rdchk(A_PE, 8'hA5);
        axi_wr(32'h0000_0004, 8'hFF, 4'hF);
        chk("unmapped bresp", {30'h0, `IEP_RESP_SLVERR}, {30'h0, resp});
        axi_rd(32'h0000_0004);
        chk("unmapped rresp", {30'h0, `IEP_RESP_SLVERR}, {30'h0, resp});
        chk("unmapped rdata", 32'h0, rdat);
    endtask
    task automatic t_gate();
        int c;
        axi_wr(A_EE, 8'h80, 4'hF);
        axi_wr(A_PE, 8'h80, 4'hF);
        @(posedge mclk);
        src_req[14] <= 1'h1;
        c = calls;
        repeat (20) @(posedge mclk);
        chk("calls global off", c, calls);
        axi_wr(A_EE, 8'h00, 4'hF);
        axi_wr(A_EB, 8'h80, 4'hF);
        repeat (20) @(posedge mclk);
        chk("calls masked", c, calls);
        axi_wr(A_EE, 8'h80, 4'hF);
        serve(14, 1'h1);
        ret();
    endtask
    task automatic t_order();
        axi_wr(A_PE, 8'h00, 4'hF);
        axi_wr(A_EE, 8'h09, 4'hF);
        @(posedge mclk);
        src_req[10] <= 1'h1;
        src_req[7] <= 1'h1;
        serve(7, 1'h0);
        chk("call latency", `IEP_DETECT_CYCLES + `IEP_CALL_CYCLES + 1, lat);
        ret();
        serve(10, 1'h0);
        ret();
    endtask
    task automatic t_preempt();
        int c;
        axi_wr(A_EB, 8'hA1, 4'hF);
        axi_wr(A_PB, 8'h20, 4'hF);
        axi_wr(A_EE, 8'h40, 4'hF);
        axi_wr(A_PE, 8'h40, 4'hF);
        @(posedge mclk);
        slow <= 1'h1;
        src_req[0] <= 1'h1;
        serve(0, 1'h0);
        @(posedge mclk);
        src_req[13] <= 1'h1;
        serve(13, 1'h1);
        @(posedge mclk);
        src_req[5] <= 1'h1;
        c = calls;
        repeat (30) @(posedge mclk);
        chk("calls under high", c, calls);
        ret();
        serve(5, 1'h1);
        ret();
        repeat (10) @(posedge mclk);
        chk("active low resumed", 32'h1, {30'h0, irq_active_r});
        ret();
        repeat (10) @(posedge mclk);
        chk("active after returns", 32'h0, {30'h0, irq_active_r});
    endtask
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'h1;
        slow = 1'h0;
        src_req = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        t_regs();
        t_gate();
        t_order();
        t_preempt();
        complete_run();
    end
endmodule
`default_nettype wire
